// ===== fslr_core.sv
// command interpreter for security registers, block locks and software reset
`timescale 1ns/100ps
`default_nettype none
module fslr_core
    import fslr_pkg::*;
#(
    parameter int PROG_CYCLES = SR_PROG_CYCLES,
    parameter int RECOVERY_CYCLES = RST_RECOVERY_CYCLES
) (
    // core clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    // configuration from the status registers
    input wire logic addr4_mode_i,
    input wire logic [SR_COUNT-1:0] secreg_otp_lock_bits_i,
    input wire logic protect_scheme_select_i,
    input wire logic bp_protect_i,
    // array write check
    input wire logic [31:0] array_addr_i,
    input wire logic array_write_req_i,
    output logic array_write_grant_o,
    output logic array_protected_o,
    // status
    output logic busy_o,
    output logic write_enable_latch_o,
    output logic recovering_o,
    output logic volatile_clear_o
);
    import fslr_pkg::*;

    localparam int PROT_N = 1 << PROT_IDX_W;

    function automatic logic sr_valid(input logic [31:0] a);
        return a[31:16] == 16'h0000 && a[11:8] == 4'h0 &&
               a[15:12] >= SR_SEL_FIRST && a[15:12] <= SR_SEL_LAST;
    endfunction

    function automatic logic [1:0] sr_sel(input logic [31:0] a);
        return a[SR_SEL_LSB +: 2] - 2'd1;
    endfunction

    function automatic logic [PROT_IDX_W-1:0] prot_idx(input logic [31:0] a);
        return a[PROT_ADDR_LSB +: PROT_IDX_W];
    endfunction

    // core-domain state
    logic write_enable_latch, next_wel;
    logic [TIMER_W-1:0] bcnt, next_bcnt;
    logic [TIMER_W-1:0] rcnt, next_rcnt;
    logic rst_en, next_rst_en;
    logic tok, next_tok;
    logic [PROT_N-1:0] prot, next_prot;
    logic vclear, next_vclear;
    logic aprot, next_aprot;
    logic agrant, next_agrant;
    logic cs_s1, cs_s2, cs_s3;

    // link-domain state
    logic started;
    fslr_phase_e phase, next_phase, cur_phase;
    logic [2:0] bitcnt, next_bitcnt, cur_cnt;
    logic [6:0] sr, next_sr;
    logic [7:0] bin;
    logic [2:0] alen, next_alen;
    logic [7:0] off, next_off;
    logic [7:0] obyte, next_obyte;
    fslr_frame_s fr, next_fr;
    logic [7:0] mem [0:SR_COUNT*SR_BYTES-1];
    logic mem_we;
    logic [9:0] mem_idx;
    logic [7:0] mem_wdata;
    logic prog_ok;
    fslr_stat_s stat_src, stat_s1, stat_s2;
    logic [PROT_N-1:0] prot_s1, prot_s2;
    logic sdo, next_sdo, sdo_oe, next_sdo_oe;

    // ---------------- link domain ----------------
    // chip select high ends the frame even though the link clock has stopped
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // status levels change between frames or when the program or recovery timer runs out; two stages settle them well before
    // the eighth edge where the opcode is judged
    always_ff @(posedge sclk_i) begin
        stat_s1 <= stat_src;
        stat_s2 <= stat_s1;
        prot_s1 <= prot;
        prot_s2 <= prot_s1;
    end

    always_comb begin
        cur_phase = started ? phase : PH_OPC;
        cur_cnt = started ? bitcnt : 3'd0;
        bin = {(started ? sr : 7'd0), serial_data_in_i};
        next_phase = cur_phase;
        next_bitcnt = cur_cnt + 3'd1;
        next_sr = bin[6:0];
        next_alen = alen;
        next_off = off;
        next_obyte = obyte;
        next_fr = fr;
        prog_ok = stat_s2.write_enable_latch && sr_valid(fr.addr) && !stat_s2.otp_lock[sr_sel(fr.addr)];
        mem_we = 1'b0;
        mem_idx = {sr_sel(fr.addr), off};
        // programming only pulls bits low, so erased locations take the new value
        mem_wdata = mem[mem_idx] & bin;
        if (!started) begin
            next_fr.ok = 1'b0;
        end
        next_fr.aligned = (next_bitcnt == 3'd0);
        if (cur_cnt == 3'd7) begin
            unique case (cur_phase)
                PH_OPC: begin
                    next_fr.opcode = bin;
                    next_fr.tok = stat_s2.tok;
                    next_fr.addr = 32'h0000_0000;
                    next_alen = stat_s2.addr4 ? ADDR_BYTES_4B : ADDR_BYTES_3B;
                    next_phase = PH_IDLE;
                    if (!stat_s2.blocked) begin
                        if (bin == OP_SR_PROG || bin == OP_SR_READ || bin == OP_LOCK ||
                            bin == OP_UNLOCK || bin == OP_LOCK_RD) begin
                            next_phase = PH_ADDR;
                        end else begin
                            next_fr.ok = 1'b1;
                        end
                    end
                end
                PH_ADDR: begin
                    next_fr.addr = {fr.addr[23:0], bin};
                    next_alen = alen - 3'd1;
                    next_off = bin;
                    if (alen == 3'd1) begin
                        if (fr.opcode == OP_SR_READ) begin
                            next_phase = PH_DUMMY;
                        end else if (fr.opcode == OP_SR_PROG) begin
                            next_phase = PH_DIN;
                        end else if (fr.opcode == OP_LOCK_RD) begin
                            next_obyte = {7'd0, prot_s2[prot_idx({fr.addr[23:0], bin})]};
                            next_phase = PH_DOUT;
                            next_fr.ok = 1'b1;
                        end else begin
                            next_phase = PH_IDLE;
                            next_fr.ok = 1'b1;
                        end
                    end
                end
                PH_DUMMY: begin
                    next_phase = PH_DOUT;
                    next_fr.ok = 1'b1;
                    next_obyte = sr_valid(fr.addr) ? mem[{sr_sel(fr.addr), off}] : SR_EMPTY_BYTE;
                end
                PH_DOUT: begin
                    if (fr.opcode == OP_SR_READ) begin
                        next_off = off + 8'd1;
                        next_obyte = sr_valid(fr.addr) ? mem[{sr_sel(fr.addr), next_off}] :
                                     SR_EMPTY_BYTE;
                    end
                end
                PH_DIN: begin
                    mem_we = prog_ok;
                    next_off = off + 8'd1;
                    next_fr.ok = 1'b1;
                end
                PH_IDLE: begin
                    next_phase = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sclk_i) begin
        phase <= next_phase;
        bitcnt <= next_bitcnt;
        sr <= next_sr;
        alen <= next_alen;
        off <= next_off;
        obyte <= next_obyte;
        fr <= next_fr;
        if (mem_we) begin
            mem[mem_idx] <= mem_wdata;
        end
    end

    always_comb begin
        next_sdo_oe = started && phase == PH_DOUT;
        next_sdo = next_sdo_oe ? obyte[~bitcnt] : 1'b0;
    end

    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
        end
    end

    assign serial_data_out_o = sdo;
    assign serial_data_out_oe_o = sdo_oe;

    // ---------------- core domain ----------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    always_comb begin
        logic frame_end;
        logic frame_new;
        logic done;
        logic blocked;
        frame_end = cs_s2 && !cs_s3;
        // the frame summary stands still once chip select is high, so it is read directly
        frame_new = frame_end && fr.tok == tok;
        done = frame_new && fr.ok && fr.aligned;
        blocked = bcnt != '0 || rcnt != '0;
        next_wel = write_enable_latch;
        next_bcnt = bcnt;
        next_rcnt = rcnt;
        next_rst_en = rst_en;
        next_tok = frame_new ? ~tok : tok;
        next_prot = prot;
        next_vclear = 1'b0;
        if (bcnt != '0) begin
            next_bcnt = bcnt - TIMER_W'(1);
            if (bcnt == TIMER_W'(1)) begin
                next_wel = 1'b0;
            end
        end
        if (rcnt != '0) begin
            next_rcnt = rcnt - TIMER_W'(1);
        end
        if (frame_new && !blocked) begin
            next_rst_en = done && fr.opcode == OP_RST_EN;
            if (done) begin
                unique case (fr.opcode)
                    OP_WREN: next_wel = 1'b1;
                    OP_WRDIS: next_wel = 1'b0;
                    OP_SR_PROG: begin
                        if (write_enable_latch && sr_valid(fr.addr) && !secreg_otp_lock_bits_i[sr_sel(fr.addr)]) begin
                            next_bcnt = TIMER_W'(PROG_CYCLES);
                        end
                    end
                    OP_LOCK: next_prot[prot_idx(fr.addr)] = 1'b1;
                    OP_UNLOCK: next_prot[prot_idx(fr.addr)] = 1'b0;
                    OP_LOCK_ALL: next_prot = '1;
                    OP_UNLOCK_ALL: next_prot = '0;
                    OP_RST: begin
                        if (rst_en) begin
                            next_wel = 1'b0;
                            next_bcnt = '0;
                            next_prot = '1;
                            next_rcnt = TIMER_W'(RECOVERY_CYCLES);
                            next_vclear = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        next_aprot = protect_scheme_select_i ? prot[prot_idx(array_addr_i)] : bp_protect_i;
        next_agrant = array_write_req_i && !next_aprot;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_enable_latch <= 1'b0;
            bcnt <= '0;
            rcnt <= '0;
            rst_en <= 1'b0;
            tok <= 1'b0;
            prot <= '1;
            vclear <= 1'b0;
            aprot <= 1'b1;
            agrant <= 1'b0;
        end else begin
            write_enable_latch <= next_wel;
            bcnt <= next_bcnt;
            rcnt <= next_rcnt;
            rst_en <= next_rst_en;
            tok <= next_tok;
            prot <= next_prot;
            vclear <= next_vclear;
            aprot <= next_aprot;
            agrant <= next_agrant;
        end
    end

    // levels from flops or stable config, passed to the link side
    assign stat_src.blocked = bcnt != '0 || rcnt != '0;
    assign stat_src.write_enable_latch = write_enable_latch;
    assign stat_src.addr4 = addr4_mode_i;
    assign stat_src.tok = tok;
    assign stat_src.otp_lock = secreg_otp_lock_bits_i;

    assign busy_o = bcnt != '0;
    assign recovering_o = rcnt != '0;
    assign write_enable_latch_o = write_enable_latch;
    assign volatile_clear_o = vclear;
    assign array_protected_o = aprot;
    assign array_write_grant_o = agrant;
endmodule // fslr_core
`default_nettype wire

// ===== fslr_core_props.sv
// assertion checker for the security register, lock and reset command block
`timescale 1ns/100ps
`default_nettype none
module fslr_core_props #(
    parameter int RECOVERY_CYCLES = fslr_pkg::RST_RECOVERY_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // serial link
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_o,
    // protection
    input wire logic protect_scheme_select_i,
    input wire logic bp_protect_i,
    input wire logic array_write_req_i,
    input wire logic array_write_grant_o,
    input wire logic array_protected_o,
    // status
    input wire logic busy_o,
    input wire logic write_enable_latch_o,
    input wire logic recovering_o,
    input wire logic volatile_clear_o
);
    logic [31:0] rec_cnt;
    logic [31:0] next_rec_cnt;
    // counts recovery cycles; a repetition this long would choke the tools
    always_comb begin
        next_rec_cnt = (rst_i || !recovering_o) ? 32'h0000_0000 : rec_cnt + 32'h0000_0001;
    end
    always_ff @(posedge clk_i) begin
        rec_cnt <= next_rec_cnt;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence rec_hold;
        recovering_o && !write_enable_latch_o ##1 recovering_o [*7];
    endsequence
    grant_rule_a: assert property (
        !$past(rst_i) |-> array_write_grant_o == ($past(array_write_req_i) && !array_protected_o))
        else $error("write grant disagrees with request and protection");
    scheme_off_a: assert property (
        !$past(rst_i) && !$past(protect_scheme_select_i) |-> array_protected_o == $past(bp_protect_i))
        else $error("protection ignores block protect field while scheme is off");
    reset_state_a: assert property (
        $fell(rst_i) && protect_scheme_select_i |->
        !write_enable_latch_o && !busy_o && !recovering_o && array_protected_o)
        else $error("state after reset is wrong");
    vclear_pulse_a: assert property (
        volatile_clear_o |=> !volatile_clear_o)
        else $error("volatile clear longer than one cycle");
    vclear_effect_a: assert property (
        volatile_clear_o |-> ##[0:2] rec_hold)
        else $error("accepted reset did not clear latch and start recovery");
    recovery_len_a: assert property (
        $fell(recovering_o) |-> rec_cnt == 32'(RECOVERY_CYCLES))
        else $error("recovery time has wrong length");
    busy_start_a: assert property (
        $rose(busy_o) |-> $past(write_enable_latch_o) && !$past(recovering_o))
        else $error("program started without latch or during recovery");
    busy_end_a: assert property (
        $fell(busy_o) |-> !write_enable_latch_o)
        else $error("latch still set after program");
    out_idle_a: assert property (
        cs_n_i |-> !serial_data_out_oe_o && !serial_data_out_o)
        else $error("data out driven while deselected");
    out_stable_a: assert property (
        sclk_i && $past(sclk_i) |-> $stable(serial_data_out_o))
        else $error("data out changed while serial clock high");
endmodule // fslr_core_props
bind fslr_core fslr_core_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_fslr_core_props (
    .clk_i, .rst_i, .sclk_i, .cs_n_i, .serial_data_out_o, .serial_data_out_oe_o,
    .protect_scheme_select_i, .bp_protect_i, .array_write_req_i, .array_write_grant_o,
    .array_protected_o, .busy_o, .write_enable_latch_o, .recovering_o, .volatile_clear_o);
`default_nettype wire

// ===== fslr_host_model.sv
// host serial controller model that frames commands for the block
`timescale 1ns/100ps
`default_nettype none
module fslr_host_model (
    // serial link
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    import fslr_pkg::*;
    logic [31:0] rx;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        sdi_o = 1'b0;
        rx = 32'h0000_0000;
        // a definite rising select edge clears the link side, which has no other reset
        #1 cs_n_o = 1'b1;
    end
    // mode 0 bit: data set while clock low, sampled on the rise
    task automatic bit_xfer(input logic b);
        sdi_o = b;
        #80 sclk_o = 1'b1;
        rx = {rx[30:0], sdo_i};
        #80 sclk_o = 1'b0;
    endtask
    // clock stands still between frames; unused data bits toggle
    task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
            input logic [23:0] d, input int nd, input int nr);
        int i;
        #1.7;
        cs_n_o = 1'b0;
        #40;
        for (i = 7; i >= 0; i--) bit_xfer(op[i]);
        for (i = 8 * na - 1; i >= 0; i--) bit_xfer(a[i]);
        for (i = 23; i >= 24 - 8 * nd; i--) bit_xfer(d[i]);
        if (op == OP_SR_READ) for (i = 0; i < 8; i++) bit_xfer(~sdi_o);
        for (i = 0; i < 8 * nr; i++) bit_xfer(~sdi_o);
        #40 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #40;
    endtask
endmodule // fslr_host_model
`default_nettype wire

// ===== fslr_pkg.sv
// shared constants, states and carriers of the security register / lock / reset command block
package fslr_pkg;
    // command codes
    localparam logic [7:0] OP_SR_PROG = 8'h42;
    localparam logic [7:0] OP_SR_READ = 8'h48;
    localparam logic [7:0] OP_LOCK = 8'h36;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_LOCK_RD = 8'h3d;
    localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDIS = 8'h04;
    // address layout of the security registers
    localparam logic [3:0] SR_SEL_FIRST = 4'h1;
    localparam logic [3:0] SR_SEL_LAST = 4'h3;
    localparam int SR_SEL_LSB = 12;
    localparam int SR_BYTES = 256;
    localparam int SR_COUNT = 3;
    localparam logic [2:0] ADDR_BYTES_3B = 3'd3;
    localparam logic [2:0] ADDR_BYTES_4B = 3'd4;
    localparam logic [7:0] SR_EMPTY_BYTE = 8'hff;
    // protection bit granularity
    localparam int PROT_IDX_W = 10;
    localparam int PROT_ADDR_LSB = 16;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int RST_RECOVERY_NS = 30000;
    localparam int RST_RECOVERY_CYCLES = (RST_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SR_PROG_NS = 2000;
    localparam int SR_PROG_CYCLES = (SR_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    typedef enum logic [2:0] {
        PH_OPC = 3'b000,
        PH_ADDR = 3'b001,
        PH_DUMMY = 3'b010,
        PH_DIN = 3'b011,
        PH_DOUT = 3'b100,
        PH_IDLE = 3'b101
    } fslr_phase_e;

    // summary of one frame, left standing by the link side when chip select rises
    typedef struct packed {
        logic tok;
        logic ok;
        logic aligned;
        logic [7:0] opcode;
        logic [31:0] addr;
    } fslr_frame_s;

    // core status handed to the link side
    typedef struct packed {
        logic blocked;
        logic write_enable_latch;
        logic addr4;
        logic tok;
        logic [2:0] otp_lock;
    } fslr_stat_s;
endpackage

// ===== tb_top.sv
// self-checking bench for the security register, lock and reset command block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import fslr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, sdi, sdo, sdo_oe, write_enable_latch, busy, rec, vclr, prot, grant;
    logic addr4 = 1'b0, scheme = 1'b1, bp = 1'b0, req = 1'b0;
    logic [2:0] otp = 3'b000;
    logic [31:0] aaddr = 32'h0000_0000;
    int error_cnt = 0, n_checks = 0, vclr_cnt = 0, oe_cnt = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (vclr === 1'b1) vclr_cnt++;
    // counts link rises at which the block drives its data output
    always @(posedge sclk) if (sdo_oe === 1'b1) oe_cnt++;
    fslr_host_model u_fslr_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
    fslr_core #(.PROG_CYCLES(50), .RECOVERY_CYCLES(1000)) u_fslr_core (
        .clk_i(clk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .serial_data_in_i(sdi),
        .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe), .addr4_mode_i(addr4),
        .secreg_otp_lock_bits_i(otp), .protect_scheme_select_i(scheme), .bp_protect_i(bp),
        .array_addr_i(aaddr), .array_write_req_i(req), .array_write_grant_o(grant),
        .array_protected_o(prot), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
        .recovering_o(rec), .volatile_clear_o(vclr));
    function automatic logic [7:0] b8(input logic x);
        return {7'h00, x};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xf(input logic [7:0] op, input logic [31:0] a, input int na,
            input logic [23:0] d, input int nd, input int nr);
        oe_cnt = 0;
        u_fslr_host_model.frame(op, a, na, d, nd, nr);
        repeat (4) @(posedge clk);
        #1;
        chk("oe_bits", 8'(8 * nr), 8'(oe_cnt));
    endtask
    task automatic pchk(input logic [31:0] a, input logic e);
        @(posedge clk);
        aaddr <= a;
        req <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("array_protected", b8(e), b8(prot));
    endtask
    // bounded wait for program and recovery to finish
    task automatic idle;
        int i;
        for (i = 0; i < 2000 && (busy !== 1'b0 || rec !== 1'b0); i++) @(posedge clk);
        #1;
        // a wait that runs out counts as a mismatch
        chk("idle", 8'h00, b8(busy | rec));
    endtask
    task automatic t_locks;
        pchk(32'h0005_0000, 1'b1);
        chk("grant", 8'h00, b8(grant));
        xf(OP_LOCK_RD, 32'h0005_0000, 3, 0, 0, 2);
        chk("lock_read", 8'h01, u_fslr_host_model.rx[7:0]);
        xf(OP_UNLOCK_ALL, 0, 0, 0, 0, 0);
        pchk(32'h0005_0000, 1'b0);
        chk("grant", 8'h01, b8(grant));
        xf(OP_LOCK, 32'h0005_0000, 3, 0, 0, 0);
        pchk(32'h0005_0000, 1'b1);
        pchk(32'h0006_0000, 1'b0);
        xf(OP_LOCK_RD, 32'h0006_0000, 3, 0, 0, 1);
        chk("lock_read", 8'h00, u_fslr_host_model.rx[7:0]);
        xf(OP_UNLOCK, 32'h0005_0000, 3, 0, 0, 0);
        pchk(32'h0005_0000, 1'b0);
        @(posedge clk);
        scheme <= 1'b0;
        bp <= 1'b1;
        pchk(32'h0005_0000, 1'b1);
        @(posedge clk);
        scheme <= 1'b1;
        bp <= 1'b0;
        xf(OP_LOCK_ALL, 0, 0, 0, 0, 0);
        pchk(32'h0006_0000, 1'b1);
        @(posedge clk);
        addr4 <= 1'b1;
        xf(OP_UNLOCK, 32'h0006_0000, 4, 0, 0, 0);
        pchk(32'h0006_0000, 1'b0);
        @(posedge clk);
        addr4 <= 1'b0;
    endtask
    task automatic t_prog;
        // offset fe of register one, so three bytes run across the wrap
        xf(OP_SR_PROG, 32'h0000_10fe, 3, 0, 3, 0);
        chk("busy", 8'h00, b8(busy));
        xf(OP_WREN, 0, 0, 0, 0, 0);
        chk("wel", 8'h01, b8(write_enable_latch));
        @(posedge clk);
        otp <= 3'b010;
        xf(OP_SR_PROG, 32'h0000_2000, 3, 0, 1, 0);
        chk("busy", 8'h00, b8(busy));
        xf(OP_SR_PROG, 32'h0000_4000, 3, 0, 1, 0);
        chk("busy", 8'h00, b8(busy));
        xf(OP_SR_PROG, 32'h0000_10fe, 3, 0, 3, 0);
        chk("busy", 8'h01, b8(busy));
        idle;
        chk("wel", 8'h00, b8(write_enable_latch));
        xf(OP_SR_READ, 32'h0000_10fe, 3, 0, 0, 3);
        chk("secreg_byte0", 8'h00, u_fslr_host_model.rx[23:16]);
        chk("secreg_byte1", 8'h00, u_fslr_host_model.rx[15:8]);
        chk("secreg_byte2", 8'h00, u_fslr_host_model.rx[7:0]);
        xf(OP_SR_READ, 32'h0000_4000, 3, 0, 0, 1);
        chk("secreg_bad", 8'hff, u_fslr_host_model.rx[7:0]);
    endtask
    task automatic t_rst;
        xf(OP_WREN, 0, 0, 0, 0, 0);
        xf(OP_UNLOCK_ALL, 0, 0, 0, 0, 0);
        idle;
        vclr_cnt = 0;
        xf(OP_RST_EN, 0, 0, 0, 0, 0);
        xf(OP_RST, 0, 0, 0, 0, 0);
        chk("vclear_count", 8'h01, 8'(vclr_cnt));
        chk("wel", 8'h00, b8(write_enable_latch));
        chk("recovering", 8'h01, b8(rec));
        pchk(32'h0005_0000, 1'b1);
        xf(OP_UNLOCK_ALL, 0, 0, 0, 0, 0);
        pchk(32'h0005_0000, 1'b1);
        idle;
        chk("recovering", 8'h00, b8(rec));
        xf(OP_RST_EN, 0, 0, 0, 0, 0);
        xf(OP_WREN, 0, 0, 0, 0, 0);
        xf(OP_RST, 0, 0, 0, 0, 0);
        chk("vclear_count", 8'h01, 8'(vclr_cnt));
        chk("wel", 8'h01, b8(write_enable_latch));
    endtask
    task automatic results;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_locks;
        t_prog;
        t_rst;
        results;
    end
    initial begin
        #300000;
        error_cnt++;
        results;
    end
endmodule // tb_top
`default_nettype wire
